// file: hw/ldtl_trip_logic.sv
// line differential trip decision logic
`timescale 1ns/100ps
`default_nettype none
module ldtl_trip_logic
	import ldtl_pkg::*;
(
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst_b,
	// settings
	input  wire logic [HS_CNT_W-1:0] hs_output_count,
	input  wire logic                hs_transfer_trip_enable,
	input  wire ldtl_mode_t          diff_mode_select,
	input  wire logic                disturbance_qual_enable,
	input  wire logic [DUR_W-1:0]    min_trip_duration,
	// differential element and channel status
	input  wire logic                diff_internal_fault,
	input  wire logic                rx_transfer_trip_x,
	input  wire logic                rx_transfer_trip_y,
	input  wire logic                rx_valid_x,
	input  wire logic                rx_valid_y,
	input  wire logic                channel_failed,
	// sequence-current change detection
	input  wire logic                positive_seq_current_change,
	input  wire logic                zero_seq_current_change,
	// trip condition inputs
	input  wire logic                comm_assisted_trip_cond,
	input  wire logic                comm_scheme_permit,
	input  wire logic                transfer_trip_cond,
	input  wire logic                switch_onto_fault_trip_cond,
	input  wire logic                switch_onto_fault_enable,
	input  wire logic                general_trip_cond,
	// unlatch and resets
	input  wire logic                unlatch_cond,
	input  wire logic                front_target_reset,
	input  wire logic                serial_target_reset,
	// programmed output equations
	input  wire logic [HS_OUTS-1:0]  hs_output_equation,
	// outputs
	output logic [HS_OUTS-1:0]       high_speed_outputs,
	output logic                     diff_trip_flag,
	output logic                     qualified_diff_trip,
	output logic                     master_trip,
	output logic                     comm_target,
	output logic                     transfer_trip_send,
	output logic                     local_disturbance_flag,
	output logic                     cycle_tick
);
	logic [TICK_W-1:0] tick_cnt_reg;
	logic              tick_reg;
	logic              xfer_enabled;
	logic              rx_xfer;
	logic              fault_reg;
	logic              fault_rise;
	logic              gate_busy;
	logic              gate_open_reg;
	logic              diff_trip_next;
	logic              diff_trip_reg;
	logic [QD_W-1:0]   qual_cnt_reg;
	logic              qual_reg;
	logic              xfer_busy;
	logic              xfer_send_reg;
	logic              dist_change;
	logic              dist_busy;
	logic              dist_active;
	logic              dist_flag_reg;
	logic              combined_cond;
	logic              combined_reg;
	logic              dur_busy;
	logic              dur_start;
	logic [DUR_W-1:0]  dur_len;
	logic              trip_reg;
	logic              unlatch_req;
	logic [HS_OUTS-1:0] hs_reg;
	ldtl_trip_state_t  state_reg;

	// free-running power-system cycle tick
	// one shared tick keeps every cycle timer in step
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == TICK_W'(CYC_CLKS - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
			tick_reg     <= 1'b0;
		end
	end
	assign cycle_tick = tick_reg;

	// forced transfer trip in the three-terminal modes
	// mode 3 falls back to transfer trip only while a channel is down
	assign xfer_enabled = hs_transfer_trip_enable
		|| (diff_mode_select == ldtl_mode_3r)
		|| ((diff_mode_select == ldtl_mode_3) && channel_failed);
	// a noisy channel drops its valid, so garbage never trips
	assign rx_xfer = xfer_enabled
		&& ((rx_transfer_trip_x && rx_valid_x) || (rx_transfer_trip_y && rx_valid_y));

	// local disturbance detector
	assign dist_change = positive_seq_current_change || zero_seq_current_change;
	ldtl_cycle_timer #(
		.WIDTH (SHORT_W)
	) u_dist_timer (
		.clock  (clock),
		.rst_b  (rst_b),
		.tick   (tick_reg),
		.start  (dist_change),
		.length (SHORT_W'(DIST_HOLD_CYC)),
		.busy   (dist_busy)
	);
	assign dist_active = dist_busy || dist_change;
	// registered so the flag leaves on a clock edge like every other status
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dist_flag_reg <= 1'b0;
		end else begin
			dist_flag_reg <= dist_active;
		end
	end
	assign local_disturbance_flag = dist_flag_reg;

	// disturbance gate lasts at most two cycles from the fault onset
	// weak infeed could hide the fault from the local detector forever
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= diff_internal_fault;
		end
	end
	assign fault_rise = diff_internal_fault && !fault_reg;
	ldtl_cycle_timer #(
		.WIDTH (SHORT_W)
	) u_gate_timer (
		.clock  (clock),
		.rst_b  (rst_b),
		.tick   (tick_reg),
		.start  (fault_rise),
		.length (SHORT_W'(DIST_GATE_CYC)),
		.busy   (gate_busy)
	);
	// gate releases once the window has run out while the fault persists
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gate_open_reg <= 1'b0;
		end else if (!diff_internal_fault) begin
			gate_open_reg <= 1'b0;
		end else if (!gate_busy && !fault_rise) begin
			gate_open_reg <= 1'b1;
		end
	end

	// differential trip flag; received transfer trip bypasses the gate
	// internal faults wait for the local detector or the window's end
	always_comb begin
		diff_trip_next = rx_xfer;
		if (diff_internal_fault) begin
			if (!disturbance_qual_enable || dist_active || gate_open_reg) begin
				diff_trip_next = 1'b1;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			diff_trip_reg <= 1'b0;
		end else begin
			diff_trip_reg <= diff_trip_next;
		end
	end
	assign diff_trip_flag = diff_trip_reg;

	// transfer trip send hold
	ldtl_cycle_timer #(
		.WIDTH (SHORT_W)
	) u_xfer_timer (
		.clock  (clock),
		.rst_b  (rst_b),
		.tick   (tick_reg),
		.start  (diff_internal_fault),
		.length (SHORT_W'(XFER_HOLD_CYC + 1)),
		.busy   (xfer_busy)
	);
	// one extra count covers the partial cycle before the first tick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			xfer_send_reg <= 1'b0;
		end else begin
			xfer_send_reg <= xfer_busy;
		end
	end
	assign transfer_trip_send = xfer_send_reg;

	// equation-qualified copy lags by three quarters of a cycle
	// a flip back inside the window restarts the count
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			qual_cnt_reg <= '0;
			qual_reg     <= 1'b0;
		end else if (diff_trip_reg == qual_reg) begin
			qual_cnt_reg <= '0;
		end else if (qual_cnt_reg == QD_W'(QUAL_DELAY_CLKS - 1)) begin
			qual_cnt_reg <= '0;
			qual_reg     <= diff_trip_reg;
		end else begin
			qual_cnt_reg <= qual_cnt_reg + QD_W'(1);
		end
	end
	assign qualified_diff_trip = qual_reg;

	// fast outputs: direct for the first N, equation otherwise
	// counts above the output total make every output direct
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hs_reg <= '0;
		end else begin
			for (int i = 0; i < HS_OUTS; i++) begin
				if (hs_output_count != HS_CNT_OFF && i < int'(hs_output_count)) begin
					hs_reg[i] <= diff_trip_next;
				end else begin
					hs_reg[i] <= hs_output_equation[i];
				end
			end
		end
	end
	assign high_speed_outputs = hs_reg;

	// combined trip conditions
	always_comb begin
		combined_cond = general_trip_cond;
		combined_cond = combined_cond || transfer_trip_cond;
		combined_cond = combined_cond || (comm_assisted_trip_cond && comm_scheme_permit);
		combined_cond = combined_cond
			|| (switch_onto_fault_trip_cond && switch_onto_fault_enable);
		if (hs_output_count != HS_CNT_OFF) begin
			combined_cond = combined_cond || diff_trip_next;
		end
	end

	// last combined level for the timer's edge detect
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			combined_reg <= 1'b0;
		end else begin
			combined_reg <= combined_cond;
		end
	end

	// minimum duration timer; setting clamped into its legal range
	always_comb begin
		if (min_trip_duration < DUR_W'(MIN_DUR_LO)) begin
			dur_len = DUR_W'(MIN_DUR_LO + 1);
		end else if (min_trip_duration > DUR_W'(MIN_DUR_HI)) begin
			dur_len = DUR_W'(MIN_DUR_HI + 1);
		end else begin
			dur_len = min_trip_duration + DUR_W'(1);
		end
	end
	assign dur_start = combined_cond && !combined_reg && !dur_busy;
	ldtl_cycle_timer #(
		.WIDTH (DUR_W)
	) u_dur_timer (
		.clock  (clock),
		.rst_b  (rst_b),
		.tick   (tick_reg),
		.start  (dur_start),
		.length (dur_len),
		.busy   (dur_busy)
	);

	// any one of the three releases a latched trip
	assign unlatch_req = unlatch_cond || front_target_reset || serial_target_reset;

	// master trip seal-in
	// the timer may retrigger while latched, so clear also waits for it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ldtl_idle;
			trip_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				ldtl_idle: begin
					if (combined_cond) begin
						state_reg <= ldtl_timing;
						trip_reg  <= 1'b1;
					end
				end
				ldtl_timing: begin
					if (!dur_busy && !dur_start) begin
						state_reg <= ldtl_latched;
					end
				end
				ldtl_latched: begin
					if (!dur_busy && !combined_cond
						&& unlatch_req) begin
						state_reg <= ldtl_idle;
						trip_reg  <= 1'b0;
					end
				end
				default: begin
					state_reg <= trip_reg ? ldtl_latched : ldtl_idle;
				end
			endcase
		end
	end
	assign master_trip = trip_reg;

	// comm target follows the transfer trip condition
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			comm_target <= 1'b0;
		end else begin
			comm_target <= transfer_trip_cond;
		end
	end
endmodule
`default_nettype wire

// file: hw/ldtl_pkg.sv
// constants and types for the line differential trip logic
package ldtl_pkg;
	localparam int unsigned CLK_HZ              = 125000000;
	localparam int unsigned SYS_HZ              = 60;
	// clock cycles per power-system cycle
	localparam int unsigned CYC_CLKS            = CLK_HZ / SYS_HZ;
	localparam int unsigned TICK_W              = 22;
	localparam int unsigned HS_OUTS             = 6;
	localparam int unsigned HS_CNT_W            = 3;
	localparam logic [2:0]  HS_CNT_OFF          = 3'h0;
	// timings in power-system cycles
	localparam int unsigned XFER_HOLD_CYC       = 8;
	localparam int unsigned DIST_HOLD_CYC       = 10;
	localparam int unsigned DIST_GATE_CYC       = 2;
	localparam int unsigned MIN_DUR_LO          = 4;
	localparam int unsigned MIN_DUR_HI          = 16000;
	localparam int unsigned DUR_W               = 14;
	localparam int unsigned SHORT_W             = 4;
	// quarters of a power-system cycle for the qualified-path delay
	localparam int unsigned QUAL_DELAY_QTR      = 3;
	localparam int unsigned QTR_CLKS            = CYC_CLKS / 4;
	localparam int unsigned QUAL_DELAY_CLKS     = QUAL_DELAY_QTR * QTR_CLKS;
	localparam int unsigned QD_W                = 22;
	// differential mode selections
	typedef enum logic [1:0] {
		ldtl_mode_2     = 2'h0,
		ldtl_mode_3     = 2'h1,
		ldtl_mode_3r    = 2'h2,
		ldtl_mode_off   = 2'h3
	} ldtl_mode_t;
	typedef enum logic [1:0] {
		ldtl_idle,
		ldtl_timing,
		ldtl_latched
	} ldtl_trip_state_t;
endpackage

// file: hw/ldtl_cycle_timer.sv
// retriggerable hold counter in power-system cycles
`timescale 1ns/100ps
`default_nettype none
module ldtl_cycle_timer
	import ldtl_pkg::*;
#(
	parameter int unsigned WIDTH = SHORT_W
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	// control
	input  wire logic             tick,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] length,
	// status
	output logic                  busy
);
	logic [WIDTH-1:0] count_reg;

	// start reloads; decrement only on the cycle tick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
		end else if (start) begin
			count_reg <= length;
		end else if (tick && count_reg != '0) begin
			count_reg <= count_reg - WIDTH'(1);
		end
	end

	assign busy = (count_reg != '0);
endmodule
`default_nettype wire

// file: sim/ldtl_remote_relay.sv
// remote relay pair seen across the differential channel
`timescale 1ns/100ps
`default_nettype none
module ldtl_remote_relay #(
	parameter int DELAY = 4
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// remote fault stimulus
	input  wire logic fault_x,
	input  wire logic fault_y,
	input  wire logic noisy,
	// received channel view
	output logic      rx_transfer_trip_x,
	output logic      rx_transfer_trip_y,
	output logic      rx_valid_x,
	output logic      rx_valid_y
);
	logic [DELAY-1:0] dx_reg;
	logic [DELAY-1:0] dy_reg;
	logic             tog_reg;
	// channel latency as a plain shift line, well inside half a cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dx_reg <= '0;
			dy_reg <= '0;
			tog_reg <= 1'b0;
		end else begin
			dx_reg <= {dx_reg[DELAY-2:0], fault_x};
			dy_reg <= {dy_reg[DELAY-2:0], fault_y};
			tog_reg <= ~tog_reg;
		end
	end
	// a noise burst shows garbage that changes every clock, never a clean level
	assign rx_transfer_trip_x = noisy ? tog_reg : dx_reg[DELAY-1];
	assign rx_transfer_trip_y = noisy ? ~tog_reg : dy_reg[DELAY-1];
	assign rx_valid_x = rst_b & ~noisy;
	assign rx_valid_y = rst_b & ~noisy;
endmodule
`default_nettype wire

// file: sim/ldtl_trip_logic_asserts.sv
// property checker for the trip logic ports
`timescale 1ns/100ps
`default_nettype none
module ldtl_trip_logic_asserts
	import ldtl_pkg::*;
(
	// clock and reset
	input wire logic                clock,
	input wire logic                rst_b,
	// causes
	input wire logic [HS_CNT_W-1:0] hs_output_count,
	input wire ldtl_mode_t          diff_mode_select,
	input wire logic                disturbance_qual_enable,
	input wire logic                diff_internal_fault,
	input wire logic                rx_transfer_trip_x,
	input wire logic                rx_valid_x,
	input wire logic                positive_seq_current_change,
	input wire logic                zero_seq_current_change,
	input wire logic                transfer_trip_cond,
	input wire logic                switch_onto_fault_trip_cond,
	input wire logic                switch_onto_fault_enable,
	input wire logic                general_trip_cond,
	// effects
	input wire logic [HS_OUTS-1:0]  high_speed_outputs,
	input wire logic                diff_trip_flag,
	input wire logic                master_trip,
	input wire logic                comm_target,
	input wire logic                transfer_trip_send,
	input wire logic                local_disturbance_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	comm_lamp_a: assert property (transfer_trip_cond |=> comm_target)
		else $error("comm target late");
	plain_trip_a: assert property ((general_trip_cond || transfer_trip_cond) |=> master_trip)
		else $error("unsupervised trip missed");
	sotf_trip_a: assert property ((switch_onto_fault_trip_cond && switch_onto_fault_enable)
		|=> master_trip) else $error("sotf trip missed");
	dist_hold_a: assert property ((positive_seq_current_change || zero_seq_current_change)
		|=> local_disturbance_flag[*8]) else $error("disturbance flag dropped");
	xfer_send_a: assert property ((diff_internal_fault && !disturbance_qual_enable)
		|-> ##2 transfer_trip_send[*8]) else $error("transfer send short");
	forced_xfer_a: assert property ((rx_transfer_trip_x && rx_valid_x
		&& diff_mode_select == ldtl_mode_3r) |=> diff_trip_flag) else $error("forced xfer lost");
	direct_out_a: assert property ((diff_trip_flag && hs_output_count != HS_CNT_OFF)
		|-> ##[0:1] high_speed_outputs[0]) else $error("direct output missing");
	diff_master_a: assert property ((diff_trip_flag && hs_output_count != HS_CNT_OFF)
		|-> ##[0:1] master_trip) else $error("diff trip not in master");
	cover property (master_trip && comm_target);
	cover property (diff_trip_flag && disturbance_qual_enable);
	cover property ($rose(transfer_trip_send));
endmodule
bind ldtl_trip_logic ldtl_trip_logic_asserts u_ldtl_trip_logic_asserts (.*);
`default_nettype wire

// file: sim/ldtl_trip_logic_tb_top.sv
// self-checking bench for the trip logic
`timescale 1ns/100ps
`default_nettype none
module ldtl_trip_logic_tb_top
	import ldtl_pkg::*;
;
	localparam int RDLY = 4;
	logic                clock, rst_b, hs_transfer_trip_enable, disturbance_qual_enable;
	logic [HS_CNT_W-1:0] hs_output_count;
	ldtl_mode_t          diff_mode_select;
	logic [DUR_W-1:0]    min_trip_duration;
	logic                diff_internal_fault, channel_failed, rx_transfer_trip_x;
	logic                rx_transfer_trip_y, rx_valid_x, rx_valid_y;
	logic                positive_seq_current_change, zero_seq_current_change;
	logic                comm_assisted_trip_cond, comm_scheme_permit, transfer_trip_cond;
	logic                switch_onto_fault_trip_cond, switch_onto_fault_enable;
	logic                general_trip_cond, unlatch_cond, front_target_reset;
	logic                serial_target_reset, diff_trip_flag, qualified_diff_trip;
	logic [HS_OUTS-1:0]  hs_output_equation, high_speed_outputs;
	logic                master_trip, comm_target, transfer_trip_send;
	logic                local_disturbance_flag, cycle_tick, fault_x, fault_y, noisy;
	int                  miscompares, n_checks;
	ldtl_trip_logic u_ldtl_trip_logic (.*);
	ldtl_remote_relay #(.DELAY(RDLY)) u_ldtl_remote_relay (.*);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	// full reset per scenario: a latched trip cannot clear inside a short run
	task automatic do_rst;
		if ($time != 0) @(posedge clock);
		rst_b <= 1'b0;
		diff_mode_select <= ldtl_mode_2;
		min_trip_duration <= 14'h0009;
		{hs_output_count, hs_transfer_trip_enable, disturbance_qual_enable, diff_internal_fault,
			channel_failed, positive_seq_current_change, zero_seq_current_change,
			comm_assisted_trip_cond, comm_scheme_permit, transfer_trip_cond,
			switch_onto_fault_trip_cond, switch_onto_fault_enable, general_trip_cond,
			unlatch_cond, front_target_reset, serial_target_reset, hs_output_equation,
			fault_x, fault_y, noisy} <= '0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
	endtask
	task automatic s_plain;
		for (int i = 0; i < 3; i++) begin
			do_rst();
			general_trip_cond <= (i != 1);
			transfer_trip_cond <= (i != 0);
			{comm_assisted_trip_cond, comm_scheme_permit} <= {2{i == 2}};
			{switch_onto_fault_trip_cond, switch_onto_fault_enable} <= {2{i == 2}};
			wt(2);
			chk("master_trip", 6'h01, 6'(master_trip));
			chk("comm_target", 6'(i != 0), 6'(comm_target));
			chk("cycle_tick", 6'h00, 6'(cycle_tick));
			@(posedge clock);
			{general_trip_cond, transfer_trip_cond} <= 2'h0;
			{comm_assisted_trip_cond, switch_onto_fault_trip_cond} <= 2'h0;
			unlatch_cond <= (i == 0);
			front_target_reset <= (i == 1);
			serial_target_reset <= (i == 2);
			wt(3);
			chk("master_trip", 6'h01, 6'(master_trip));
			chk("comm_target", 6'h00, 6'(comm_target));
		end
	endtask
	task automatic s_super;
		do_rst();
		comm_assisted_trip_cond <= 1'b1;
		switch_onto_fault_trip_cond <= 1'b1;
		wt(4);
		chk("master_trip", 6'h00, 6'(master_trip));
		@(posedge clock);
		switch_onto_fault_enable <= 1'b1;
		wt(2);
		chk("master_trip", 6'h01, 6'(master_trip));
		do_rst();
		comm_assisted_trip_cond <= 1'b1;
		comm_scheme_permit <= 1'b1;
		wt(2);
		chk("master_trip", 6'h01, 6'(master_trip));
	endtask
	task automatic s_direct;
		logic [5:0] m;
		for (int n = 0; n <= HS_OUTS; n++) begin
			m = 6'((1 << n) - 1);
			do_rst();
			hs_output_count <= HS_CNT_W'(n);
			hs_output_equation <= 6'h2A & ~m;
			diff_internal_fault <= 1'b1;
			wt(3);
			chk("high_speed_outputs", m | (6'h2A & ~m), high_speed_outputs);
			chk("diff_trip_flag", 6'h01, 6'(diff_trip_flag));
			chk("master_trip", 6'(n != 0), 6'(master_trip));
			chk("qualified_diff_trip", 6'h00, 6'(qualified_diff_trip));
			chk("transfer_trip_send", 6'h01, 6'(transfer_trip_send));
		end
	endtask
	// rows: noisy, enable, mode, channel failed, expected flag
	task automatic s_xfer;
		logic [5:0] tbl [6];
		tbl = '{6'h11, 6'h00, 6'h04, 6'h09, 6'h07, 6'h30};
		for (int k = 0; k < 6; k++) begin
			do_rst();
			disturbance_qual_enable <= 1'b1;
			noisy <= tbl[k][5];
			hs_transfer_trip_enable <= tbl[k][4];
			diff_mode_select <= ldtl_mode_t'(tbl[k][3:2]);
			channel_failed <= tbl[k][1];
			fault_x <= k[0];
			fault_y <= ~k[0];
			wt(RDLY + 3);
			chk("diff_trip_flag", 6'(tbl[k][0]), 6'(diff_trip_flag));
		end
	endtask
	task automatic s_dist;
		for (int k = 0; k < 2; k++) begin
			do_rst();
			disturbance_qual_enable <= 1'b1;
			diff_internal_fault <= 1'b1;
			wt(20);
			chk("diff_trip_flag", 6'h00, 6'(diff_trip_flag));
			chk("local_disturbance_flag", 6'h00, 6'(local_disturbance_flag));
			@(posedge clock);
			positive_seq_current_change <= (k == 0);
			zero_seq_current_change <= (k == 1);
			@(posedge clock);
			{positive_seq_current_change, zero_seq_current_change} <= 2'h0;
			wt(12);
			chk("local_disturbance_flag", 6'h01, 6'(local_disturbance_flag));
			chk("diff_trip_flag", 6'h01, 6'(diff_trip_flag));
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		#800000;
		miscompares++;
		give_verdict();
	end
	initial begin
		miscompares = 0;
		n_checks = 0;
		do_rst();
		s_plain();
		s_super();
		s_direct();
		s_xfer();
		s_dist();
		give_verdict();
	end
endmodule
`default_nettype wire
